// file: ddr_axi_port.sv
// Purpose: one fabric-facing port of the memory controller, with a small backing store
// Assumes: master keeps tags, lengths and last flags consistent
// Notes:   instantiated once by the testbench; store stands in for the controller core
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - two independent ports, each with 128-bit read and write data
// - memory side is a x16 phy for ddr3, ddr3l, lpddr3, lpddr2 up to 1066 Mbps
// - phy reachable only through this controller, no direct fabric path
// - separate calibration bus reaches configuration registers
// - one shared request channel; direction 0 read, 1 write
// - later beat addresses come from burst kind and beat size
// - 8-bit length field gives beat count minus one
// - 8-bit request tag, read or write by direction
// - request transfers when valid and accept are both high
// - write response carries tag, held until bready
// - read beats are 128 bits and carry the request tag
// - rlast high on final read beat only
// - each read beat carries a 2-bit response code
// - read beat held stable until rready
// - sixteen byte enables; only enabled lanes are stored
// - write beat transfers when wvalid and wready are high
module ddr_axi_port #(
    parameter int MEM_LOG2 = ddr_port_pkg::MEM_WORDS_LOG2
) (
    input  wire logic                              ref_clk,
    input  wire logic                              srst,
    input  wire logic                              req_dir_select,
    input  wire logic [ddr_port_pkg::ADDR_W-1:0]   shared_req_addr,
    input  wire logic [1:0]                        shared_burst_kind,
    input  wire logic [2:0]                        shared_beat_size,
    input  wire logic [ddr_port_pkg::LEN_W-1:0]    shared_burst_len,
    input  wire logic [ddr_port_pkg::TAG_W-1:0]    shared_req_tag,
    input  wire logic [1:0]                        shared_lock_kind,
    input  wire logic                              shared_req_valid,
    output logic                                   shared_req_accept,
    input  wire logic [ddr_port_pkg::DATA_W-1:0]   wdata,
    input  wire logic [ddr_port_pkg::TAG_W-1:0]    wid,
    input  wire logic                              wlast,
    input  wire logic [ddr_port_pkg::STRB_W-1:0]   wstrb,
    input  wire logic                              wvalid,
    output logic                                   wready,
    output logic [ddr_port_pkg::TAG_W-1:0]         bid,
    output logic                                   bvalid,
    input  wire logic                              bready,
    output logic [ddr_port_pkg::DATA_W-1:0]        rdata,
    output logic [ddr_port_pkg::TAG_W-1:0]         rid,
    output logic                                   rlast,
    output logic [1:0]                             rresp,
    output logic                                   rvalid,
    input  wire logic                              rready
);
    localparam int RW = ddr_port_pkg::DATA_W + ddr_port_pkg::TAG_W + 3;
    // widest legal beat is the full bus
    localparam logic [2:0] SIZE_MAX = 3'(ddr_port_pkg::BYTE_SHIFT);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_RESP  = 2'b11,
        ST_READ  = 2'b10
    } port_state_e;

    port_state_e                          state_ff;
    logic [ddr_port_pkg::ADDR_W-1:0]      addr_ff;
    logic [ddr_port_pkg::ADDR_W-1:0]      nxt_addr;
    logic [ddr_port_pkg::ADDR_W-1:0]      wrap_mask;
    logic [ddr_port_pkg::ADDR_W-1:0]      step;
    logic [1:0]                           kind_ff;
    logic [2:0]                           size_ff;
    logic [ddr_port_pkg::LEN_W-1:0]       len_ff;
    logic [ddr_port_pkg::LEN_W-1:0]       beats_left_ff;
    logic [ddr_port_pkg::TAG_W-1:0]       tag_ff;
    logic                                 lock_ff;
    logic                                 bad_ff;
    logic                                 accept_ff;
    logic                                 wready_ff;
    logic [ddr_port_pkg::TAG_W-1:0]       bid_ff;
    logic                                 bvalid_ff;
    logic [ddr_port_pkg::DATA_W-1:0]      store_ff [2**MEM_LOG2];
    logic [MEM_LOG2-1:0]                  word_idx;
    logic                                 req_take;
    logic                                 w_take;
    logic                                 rd_push;
    logic                                 rd_push_ready;
    logic [RW-1:0]                        rd_in;
    logic [RW-1:0]                        rd_out;
    logic                                 rd_out_valid;
    logic [ddr_port_pkg::DATA_W-1:0]      rdata_ff;
    logic [ddr_port_pkg::TAG_W-1:0]       rid_ff;
    logic                                 rlast_ff;
    logic [1:0]                           rresp_ff;
    logic                                 rvalid_ff;
    logic                                 out_load;
    logic [ddr_port_pkg::DATA_W-1:0]      rd_word;
    logic                                 rd_last;
    logic [1:0]                           rd_resp;
    logic                                 kind_reserved;
    logic                                 size_too_wide;

    ////////////////////////////////////////////////////////////////////////////
    // request channel
    assign req_take = shared_req_valid && accept_ff;
    assign w_take   = wvalid && wready_ff;
    assign word_idx = addr_ff[ddr_port_pkg::BYTE_SHIFT +: MEM_LOG2];

    // accept only while idle, so a response never precedes its request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            accept_ff <= 1'b0;
        end else begin
            accept_ff <= (state_ff == ST_IDLE) && !req_take;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (req_take) begin
                        state_ff <= (req_dir_select == ddr_port_pkg::DIR_WRITE) ?
                                    ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (w_take && wlast) begin
                        state_ff <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (bvalid_ff && bready) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (rd_push && beats_left_ff == '0) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // burst address sequencing
    always_comb begin
        step      = ddr_port_pkg::ADDR_W'(1) << size_ff;
        wrap_mask = (ddr_port_pkg::ADDR_W'(len_ff) + 1'b1) * step - 1'b1;
        unique case (kind_ff)
            ddr_port_pkg::BURST_FIXED: nxt_addr = addr_ff;
            ddr_port_pkg::BURST_WRAP:
                nxt_addr = (addr_ff & ~wrap_mask) | ((addr_ff + step) & wrap_mask);
            default: nxt_addr = addr_ff + step;
        endcase
    end

    // first beat address at the take, then nxt_addr for the burst kind per beat moved
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addr_ff <= '0;
        end else if (req_take) begin
            addr_ff <= shared_req_addr;
        end else if (w_take || rd_push) begin
            addr_ff <= nxt_addr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            beats_left_ff <= '0;
        end else if (req_take) begin
            beats_left_ff <= shared_burst_len;
        end else if (w_take || rd_push) begin
            beats_left_ff <= beats_left_ff - 1'b1;
        end
    end

    // lock kind is kept but has no effect: one request at a time is already atomic
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            kind_ff <= ddr_port_pkg::BURST_INCR;
            size_ff <= '0;
            len_ff  <= '0;
            tag_ff  <= '0;
            lock_ff <= 1'b0;
        end else if (req_take) begin
            kind_ff <= shared_burst_kind;
            size_ff <= shared_beat_size;
            len_ff  <= shared_burst_len;
            tag_ff  <= shared_req_tag;
            lock_ff <= shared_lock_kind[0];
        end
    end

    // reserved burst kind and beats wider than the bus give SLVERR on read beats; such writes store nothing
    assign kind_reserved = shared_burst_kind > ddr_port_pkg::BURST_WRAP;
    assign size_too_wide = shared_beat_size > SIZE_MAX;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bad_ff <= 1'b0;
        end else if (req_take) begin
            bad_ff <= kind_reserved || size_too_wide;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data and response
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wready_ff <= 1'b0;
        end else begin
            wready_ff <= (state_ff == ST_WRITE) && !(w_take && wlast);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (w_take && !bad_ff) begin
            for (int b = 0; b < ddr_port_pkg::STRB_W; b++) begin
                if (wstrb[b]) begin
                    store_ff[word_idx][8*b +: 8] <= wdata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bvalid_ff <= 1'b0;
            bid_ff    <= '0;
        end else if (w_take && wlast) begin
            bvalid_ff <= 1'b1;
            bid_ff    <= tag_ff;
        end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data through a two-entry buffer
    assign rd_push = (state_ff == ST_READ) && rd_push_ready;
    assign rd_word = store_ff[word_idx];
    assign rd_last = (beats_left_ff == '0);
    assign rd_resp = bad_ff ? ddr_port_pkg::RESP_SLVERR : ddr_port_pkg::RESP_OKAY;
    assign rd_in   = {rd_word, tag_ff, rd_last, rd_resp};

    ddr_beat_buffer #(
        .WIDTH (RW),
        .DEPTH (2)
    ) u_rd_buf (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_data   (rd_in),
        .in_valid  (state_ff == ST_READ),
        .in_ready  (rd_push_ready),
        .out_data  (rd_out),
        .out_valid (rd_out_valid),
        .out_ready (out_load)
    );

    assign out_load = rd_out_valid && (!rvalid_ff || rready);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rid_ff    <= '0;
            rlast_ff  <= 1'b0;
            rresp_ff  <= ddr_port_pkg::RESP_OKAY;
        end else if (out_load) begin
            rvalid_ff <= 1'b1;
            {rdata_ff, rid_ff, rlast_ff, rresp_ff} <= rd_out;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign shared_req_accept = accept_ff;
    assign wready            = wready_ff;
    assign bid               = bid_ff;
    assign bvalid            = bvalid_ff;
    assign rdata             = rdata_ff;
    assign rid               = rid_ff;
    assign rlast             = rlast_ff;
    assign rresp             = rresp_ff;
    assign rvalid            = rvalid_ff;
    // wid is not checked; single outstanding write keeps beats in order
    // one instance per fabric clock; phy and calibration sit in the hard core
endmodule

// file: ddr_port_pkg.sv
// Purpose: shared constants for the dual fabric memory port
// Assumes: single 100 MHz clock, synchronous active-high reset
// Notes:   burst kinds and response codes follow the public AXI encoding
package ddr_port_pkg;
    localparam int DATA_W      = 128;
    localparam int STRB_W      = 16;
    localparam int ADDR_W      = 32;
    localparam int TAG_W       = 8;
    localparam int LEN_W       = 8;
    localparam int NUM_PORTS   = 2;
    localparam int LANE_RATE_MBPS_MAX = 1066;
    localparam int PHY_WIDTH   = 16;
    localparam logic DIR_READ  = 1'b0;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic [1:0] BURST_FIXED = 2'h0;
    localparam logic [1:0] BURST_INCR  = 2'h1;
    localparam logic [1:0] BURST_WRAP  = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int MEM_WORDS_LOG2 = 6;
    localparam int BYTE_SHIFT  = 4;
endpackage

// file: ddr_beat_buffer.sv
// Purpose: two-entry valid/ready skid buffer
// Assumes: single clock domain
// Notes:   full throughput; stalls on drain side propagate upstream
`timescale 1ns/1ps
module ddr_beat_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (PW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// file: ddr_axi_port_asserts.sv
// Purpose: protocol checks on one fabric port
// Assumes: one transaction outstanding at a time
// Notes:   tag and length captured at request take
`timescale 1ns/1ps
module ddr_axi_port_asserts (
    input wire logic         ref_clk,
    input wire logic         srst,
    input wire logic         req_dir_select,
    input wire logic [7:0]   shared_burst_len,
    input wire logic [7:0]   shared_req_tag,
    input wire logic         shared_req_valid,
    input wire logic         shared_req_accept,
    input wire logic         wlast,
    input wire logic         wvalid,
    input wire logic         wready,
    input wire logic [7:0]   bid,
    input wire logic         bvalid,
    input wire logic         bready,
    input wire logic [127:0] rdata,
    input wire logic [7:0]   rid,
    input wire logic         rlast,
    input wire logic [1:0]   rresp,
    input wire logic         rvalid,
    input wire logic         rready
);
logic [7:0] rd_tag_ff;
logic [7:0] wr_tag_ff;
logic [7:0] len_ff;
logic [7:0] beat_ff;
logic [8:0] pend_ff;
logic       rd_take;
logic       r_hs;
assign rd_take = shared_req_valid && shared_req_accept && !req_dir_select;
assign r_hs    = rvalid && rready;
// read and write tags kept apart; the bench drains one read before the next
always_ff @(posedge ref_clk) begin
    if (shared_req_valid && shared_req_accept && req_dir_select) wr_tag_ff <= shared_req_tag;
    if (rd_take) begin
        rd_tag_ff <= shared_req_tag;
        len_ff    <= shared_burst_len;
    end
end
// accept may rise while read beats still drain, so count beats owed instead
always_ff @(posedge ref_clk) begin
    if (srst) begin
        beat_ff <= 8'h00;
        pend_ff <= 9'h000;
    end else begin
        if (r_hs) beat_ff <= rlast ? 8'h00 : beat_ff + 8'h01;
        pend_ff <= pend_ff + (rd_take ? {1'b0, shared_burst_len} + 9'h001 : 9'h000)
                   - {8'h00, r_hs};
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge ref_clk); endclocking
default disable iff (srst);
sequence s_take; shared_req_valid && shared_req_accept; endsequence
sequence s_wr_end; wvalid && wready && wlast; endsequence
a_accept_drop: assert property (s_take |=> !shared_req_accept)
    else $error("accept stayed high after take");
a_wready_write: assert property (s_take ##0 req_dir_select |=> ##1 wready)
    else $error("no write ready after write request");
a_read_no_wready: assert property (s_take ##0 !req_dir_select |=> !wready [*2])
    else $error("write ready after read request");
a_bvalid_after: assert property (s_wr_end |=> bvalid && !wready)
    else $error("no response after last write beat");
a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bid))
    else $error("write response dropped early");
a_bid_tag: assert property (bvalid |-> bid == wr_tag_ff)
    else $error("write response tag wrong");
a_rbeat_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rid, rlast, rresp}))
    else $error("read beat changed before accept");
a_rid_tag: assert property (rvalid |-> rid == rd_tag_ff)
    else $error("read tag wrong");
a_rlast_beat: assert property (rvalid |-> rlast == (beat_ff == len_ff))
    else $error("last flag on wrong beat");
a_read_start: assert property (s_take ##0 !req_dir_select |-> ##[1:8] rvalid)
    else $error("read data never started");
a_idle_quiet: assert property (shared_req_accept |-> !bvalid && !wready)
    else $error("response while idle");
a_read_owed: assert property (rvalid |-> pend_ff != 9'h000)
    else $error("read beat with no request owed");
endmodule

// file: ddr_fabric_sink.sv
// Purpose: fabric master response side, with optional stalls
// Assumes: stall is a level from the bench
// Notes:   stalls long enough to fill the beat buffer
`timescale 1ns/1ps
module ddr_fabric_sink (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic stall,
    output logic     rready,
    output logic     bready
);
logic [1:0] cnt_ff;
always_ff @(posedge ref_clk) begin
    if (srst) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
end
always_ff @(posedge ref_clk) begin
    rready <= !srst && (!stall || cnt_ff == 2'h0);
    bready <= !srst && (!stall || cnt_ff == 2'h3);
end
endmodule

// file: dual_axi_ddr_memory_port_tb.sv
// Purpose: self-checking bench for one fabric port
// Assumes: beat size 16 bytes for data scenarios
// Notes:   expected store kept in mem
`timescale 1ns/1ps
module dual_axi_ddr_memory_port_tb;
logic         ref_clk = 1'b0;
logic         srst = 1'b1;
logic         req_dir_select = 1'b0;
logic [31:0]  shared_req_addr = 32'h0;
logic [1:0]   shared_burst_kind = 2'h0;
logic [2:0]   shared_beat_size = 3'h0;
logic [7:0]   shared_burst_len = 8'h0;
logic [7:0]   shared_req_tag = 8'h0;
logic [1:0]   shared_lock_kind = 2'h0;
logic         shared_req_valid = 1'b0;
logic [127:0] wdata = 128'h0;
logic [7:0]   wid = 8'h0;
logic         wlast = 1'b0;
logic [15:0]  wstrb = 16'h0;
logic         wvalid = 1'b0;
logic         stall = 1'b0;
logic         shared_req_accept, wready, bvalid, bready, rlast, rvalid, rready;
logic [7:0]   bid, rid;
logic [127:0] rdata;
logic [1:0]   rresp;
logic [127:0] mem [64];
int           err_total = 0;
int           checks_done = 0;
int           cyc = 0;
always #5 ref_clk = ~ref_clk;
ddr_axi_port u_dut (.*);
ddr_fabric_sink u_sink (.*);
////////////////////////////////////////////////////////////////////////////////
task automatic conclude;
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
function automatic logic [5:0] word_at(logic [1:0] k, logic [5:0] w0, logic [5:0] l, int i);
    case (k)
        ddr_port_pkg::BURST_FIXED: return w0;
        ddr_port_pkg::BURST_WRAP: return (w0 & ~l) | ((w0 + 6'(i)) & l);
        default: return w0 + 6'(i);
    endcase
endfunction
task automatic req(logic d, logic [31:0] a, logic [1:0] k, logic [2:0] s, logic [7:0] l, logic [7:0] t);
    req_dir_select <= d;
    shared_req_addr <= a;
    shared_burst_kind <= k;
    shared_beat_size <= s;
    shared_burst_len <= l;
    shared_req_tag <= t;
    shared_lock_kind <= 2'h0;
    shared_req_valid <= 1'b1;
    @(posedge ref_clk);
    while (shared_req_accept !== 1'b1) @(posedge ref_clk);
    shared_req_valid <= 1'b0;
endtask
task automatic wr(logic [1:0] k, logic [31:0] a, logic [7:0] l, logic [7:0] t, logic [15:0] st);
    logic [127:0] d;
    logic [5:0]   w;
    req(ddr_port_pkg::DIR_WRITE, a, k, 3'h4, l, t);
    for (int i = 0; i <= l; i++) begin
        d = {16{8'(t + 8'(i))}};
        w = word_at(k, a[9:4], l[5:0], i);
        wdata <= d;
        wstrb <= st;
        wid <= t;
        wlast <= (i == l);
        wvalid <= 1'b1;
        @(posedge ref_clk);
        while (wready !== 1'b1) @(posedge ref_clk);
        for (int b = 0; b < 16; b++) if (st[b]) mem[w][8*b +: 8] = d[8*b +: 8];
        st = {st[11:0], st[15:12]};
    end
    wvalid <= 1'b0;
    wlast <= 1'b0;
    while (!(bvalid === 1'b1 && bready === 1'b1)) @(posedge ref_clk);
    chk(bid, t);
endtask
task automatic rd(logic [1:0] k, logic [2:0] s, logic [31:0] a, logic [7:0] l, logic [7:0] t);
    logic bad;
    bad = (k == 2'h3) || (s > 3'h4);
    req(ddr_port_pkg::DIR_READ, a, k, s, l, t);
    for (int i = 0; i <= l; i++) begin
        @(posedge ref_clk);
        while (!(rvalid === 1'b1 && rready === 1'b1)) @(posedge ref_clk);
        chk(rid, t);
        chk(rlast, i == l);
        chk(rresp, bad ? ddr_port_pkg::RESP_SLVERR : ddr_port_pkg::RESP_OKAY);
        if (!bad) chk(rdata, mem[word_at(k, a[9:4], l[5:0], i)]);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic s_reset;
    chk({shared_req_accept, wready, bvalid, rvalid}, 4'h0);
endtask
task automatic s_incr;
    // stalls make the two-entry buffer fill
    stall <= 1'b1;
    wr(ddr_port_pkg::BURST_INCR, 32'h80, 8'h03, 8'h11, 16'hFFFF);
    rd(ddr_port_pkg::BURST_INCR, 3'h4, 32'h80, 8'h03, 8'h12);
    stall <= 1'b0;
endtask
task automatic s_wrap;
    rd(ddr_port_pkg::BURST_WRAP, 3'h4, 32'hA0, 8'h03, 8'hFF);
endtask
task automatic s_fixed;
    wr(ddr_port_pkg::BURST_INCR, 32'h140, 8'h00, 8'h30, 16'hFFFF);
    wr(ddr_port_pkg::BURST_FIXED, 32'h140, 8'h01, 8'h31, 16'h00FF);
    rd(ddr_port_pkg::BURST_FIXED, 3'h4, 32'h140, 8'h01, 8'h32);
endtask
task automatic s_err;
    rd(2'h3, 3'h4, 32'h80, 8'h01, 8'h41);
    rd(ddr_port_pkg::BURST_INCR, 3'h5, 32'h80, 8'h00, 8'h42);
endtask
initial begin
    repeat (10) @(posedge ref_clk);
    s_reset();
    srst <= 1'b0;
    @(posedge ref_clk);
    s_incr();
    s_wrap();
    s_fixed();
    s_err();
    conclude();
end
always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
        err_total++;
        conclude();
    end
end
endmodule
bind ddr_axi_port ddr_axi_port_asserts u_chk (.*);
